//--- rail_seq_pkg.sv
// Shared constants and types for the rail enable sequencer.
// Assumes a single 25 MHz system clock for every user of this package.
package rail_seq_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RESEQ_HOLD_US = 4500;
  localparam int unsigned RESEQ_HOLD_CYC = CLK_HZ / 1_000_000 * RESEQ_HOLD_US;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  // Counter widths sized for the default counts
  localparam int unsigned HOLD_W = 17;
  localparam int unsigned TICK_W = 15;

  // Channel layout: rails 1..8 are channels 0..7, general outs 1..4 are 8..11
  localparam int unsigned NUM_RAILS = 8;
  localparam int unsigned NUM_GPO = 4;
  localparam int unsigned NUM_CH = NUM_RAILS + NUM_GPO;
  localparam int unsigned CH_RAIL8 = 7;
  localparam int unsigned CH_GENERAL_OUT_ONE = 8;
  localparam int unsigned VOLT_W = 10;
  localparam int unsigned DLY_W = 16;
  localparam int unsigned PAR_W = 3;
  localparam int unsigned ADDR_SEL_W = 4;

  // Seven-bit bus address: fixed upper bits, select pins on bits 3..0
  localparam logic [7:0] BUS_ADDR_BASE = 8'h60;
  localparam int unsigned BUS_ADDR_LSB = 0;
  localparam logic [7:0] RESTART_VALUE = 8'h00;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_TIME = 2'h1,
    MODE_PARENT_REG = 2'h2,
    MODE_PARENT_THR = 2'h3
  } seq_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_LATCH = 3'h2,
    ST_RUN = 3'h4
  } seq_state_t;

endpackage

//--- seq_trigger.sv
// One sequencing trigger: decides when a single output becomes asserted.
// Assumes run_in is low for the whole of every sequencer reset.
`timescale 1ns/1ps
module seq_trigger
  import rail_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Sequencer status
  input wire logic run_in,
  input wire logic ms_tick_in,
  // Configuration
  input wire rail_seq_pkg::seq_mode_t mode_in,
  input wire logic [rail_seq_pkg::DLY_W-1:0] delay_ms_in,
  input wire logic [rail_seq_pkg::VOLT_W-1:0] threshold_in,
  // Parent rail
  input wire logic parent_in_reg_in,
  input wire logic [rail_seq_pkg::VOLT_W-1:0] parent_volt_in,
  // Result
  output logic fired_out
);
  import rail_seq_pkg::*;

  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic fired;
  } trig_state_t;

  trig_state_t r, n;

  always_comb begin
    n = r;
    if (!run_in) begin
      n.cnt = '0;
      n.fired = 1'b0;
    end else if (!r.fired) begin
      case (mode_in)
        MODE_TIME: begin
          if (r.cnt >= delay_ms_in) begin
            n.fired = 1'b1;
          end else if (ms_tick_in) begin
            n.cnt = r.cnt + 1'b1;
          end
        end
        MODE_PARENT_REG: begin
          // Parent dropping out before the delay ends restarts the wait
          if (!parent_in_reg_in) begin
            n.cnt = '0;
          end else if (r.cnt >= delay_ms_in) begin
            n.fired = 1'b1;
          end else if (ms_tick_in) begin
            n.cnt = r.cnt + 1'b1;
          end
        end
        MODE_PARENT_THR: begin
          if (parent_volt_in >= threshold_in) begin
            n.fired = 1'b1;
          end
        end
        default: begin
          n.fired = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else if (clk_en_in) begin
      r <= n;
    end
  end

  assign fired_out = r.fired;

  default clocking cb @(posedge clk_sys_in iff clk_en_in);
  endclocking
  default disable iff (rst_in);

  AST_TIME_FIRE: assert property (
    (run_in && mode_in == MODE_TIME && !r.fired && r.cnt >= delay_ms_in)
    |=> (r.fired || !$past(run_in)))
    else $error("time trigger missed its delay");
  AST_PARENT_WAIT: assert property (
    ($rose(r.fired) && $past(mode_in) == MODE_PARENT_REG)
    |-> ($past(parent_in_reg_in) && $past(r.cnt) >= $past(delay_ms_in)))
    else $error("parent trigger fired without regulated parent");
  AST_THR_FIRE: assert property (
    (run_in && !r.fired && mode_in == MODE_PARENT_THR
     && parent_volt_in >= threshold_in) |=> r.fired)
    else $error("threshold trigger did not fire");
  AST_OFF_QUIET: assert property (
    (mode_in == MODE_OFF && !r.fired) |=> !r.fired)
    else $error("excluded output became asserted");
  AST_CLEAR: assert property (
    !run_in |=> (!r.fired && r.cnt == '0))
    else $error("trigger not cleared by sequencer reset");
  AST_HOLD_FIRED: assert property (
    (r.fired && run_in) |=> (r.fired || !$past(run_in)))
    else $error("asserted output dropped while running");

endmodule // seq_trigger

//--- rail_enable_sequencer.sv
// Rail enable sequencer: eight rail enables and four general outputs.
// Assumes voltages, limits and the restart write come from logic on
// clk_sys_in; reset, power-good and address pins come from outside.
`timescale 1ns/1ps

// What this block does
// - Time mode asserts an output a set delay after sequencer reset ends.
// - Parent-regulation mode asserts a set delay after parent enters regulation.
// - A rail is regulated only while its voltage sits within its limits.
// - Threshold mode asserts once parent voltage reaches the set threshold.
// - An excluded rail never drives its enable but may still be monitored.
// - Eight rail enables, each with its own sequencing setup.
// - Each rail enable has a selectable asserted level.
// - The eighth enable pin may serve as general output one instead.
// - Four general outputs use the same three sequencing triggers.
// - From the cycle after sequencer reset begins, every enable and general output floats.
// - External active-low reset input held low forces sequencer reset.
// - Power-up and power cycling force sequencer reset.
// - A resequencing rail alarm forces sequencer reset.
// - A restart write of zero forces sequencer reset.
// - General pins act as outputs only after address selection ends.
// - Address pins are latched on reset release above the fixed base.
// - Alarm resequence floats outputs about 4.5 ms, then reruns sequence.
module rail_enable_sequencer
  import rail_seq_pkg::*;
#(
  parameter int unsigned RESEQ_HOLD_CYCLES = rail_seq_pkg::RESEQ_HOLD_CYC,
  parameter int unsigned MS_CYCLES = rail_seq_pkg::TICK_CYC
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Reset sources
  input wire logic ext_reset_n_in,
  input wire logic power_ok_in,
  input wire logic alarm_reseq_in,
  input wire logic restart_wr_in,
  input wire logic [7:0] restart_data_in,
  // Rail monitoring
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0][rail_seq_pkg::VOLT_W-1:0]
    rail_sense_in,
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0][rail_seq_pkg::VOLT_W-1:0]
    uv_limit_in,
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0][rail_seq_pkg::VOLT_W-1:0]
    ov_limit_in,
  // Per-channel sequencing setup
  input wire logic [rail_seq_pkg::NUM_CH-1:0][1:0] ch_mode_in,
  input wire logic [rail_seq_pkg::NUM_CH-1:0][rail_seq_pkg::PAR_W-1:0]
    ch_parent_in,
  input wire logic [rail_seq_pkg::NUM_CH-1:0][rail_seq_pkg::DLY_W-1:0]
    ch_delay_ms_in,
  input wire logic [rail_seq_pkg::NUM_CH-1:0][rail_seq_pkg::VOLT_W-1:0]
    ch_threshold_in,
  input wire logic [rail_seq_pkg::NUM_CH-1:0] ch_active_high_in,
  input wire logic rail8_as_gpo_in,
  // Address select pins
  input wire logic [rail_seq_pkg::ADDR_SEL_W-1:0] bus_addr_select_in,
  // Enable and general output pins
  output logic [rail_seq_pkg::NUM_RAILS-2:0] rail_enable_out,
  output logic [rail_seq_pkg::NUM_RAILS-2:0] rail_enable_oe_out,
  output logic rail8_enable_out,
  output logic rail8_enable_oe_out,
  output logic [rail_seq_pkg::NUM_GPO-2:0] general_out,
  output logic [rail_seq_pkg::NUM_GPO-2:0] general_oe_out,
  // Status
  output logic seq_reset_out,
  output logic [7:0] bus_addr_out,
  output logic [rail_seq_pkg::NUM_RAILS-1:0] rail_in_reg_out
);
  import rail_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESEQ_HOLD_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);

  typedef struct packed {
    seq_state_t state;
    logic [HOLD_W-1:0] hold_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic ms_tick;
    logic [1:0] ext_rst_n_sync;
    logic [1:0] pwr_ok_sync;
    logic [ADDR_SEL_W-1:0] addr_s1;
    logic [ADDR_SEL_W-1:0] addr_s2;
    logic [ADDR_SEL_W-1:0] addr;
    logic [NUM_RAILS-1:0] in_reg;
    logic [NUM_RAILS-2:0] rail_drv;
    logic [NUM_RAILS-2:0] rail_oe;
    logic pin8_drv;
    logic pin8_oe;
    logic [NUM_GPO-2:0] gpo_drv;
    logic [NUM_GPO-2:0] gpo_oe;
  } top_state_t;

  top_state_t r, n;
  logic [NUM_CH-1:0] fired;
  logic [NUM_CH-1:0] ch_level;
  logic [NUM_CH-1:0] ch_used;
  logic run;
  logic level_rst;
  logic event_rst;
  logic general_out_one;

  function automatic logic in_window(input logic [VOLT_W-1:0] v,
                                     input logic [VOLT_W-1:0] lo,
                                     input logic [VOLT_W-1:0] hi);
    in_window = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic pin_level(input logic asserted,
                                     input logic active_high);
    pin_level = ~(asserted ^ active_high);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Triggers, one per channel

  assign run = (r.state == ST_RUN);

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      seq_trigger u_trig (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .run_in(run),
        .ms_tick_in(r.ms_tick),
        .mode_in(seq_mode_t'(ch_mode_in[i])),
        .delay_ms_in(ch_delay_ms_in[i]),
        .threshold_in(ch_threshold_in[i]),
        .parent_in_reg_in(r.in_reg[ch_parent_in[i]]),
        .parent_volt_in(rail_sense_in[ch_parent_in[i]]),
        .fired_out(fired[i])
      );
      assign ch_level[i] = pin_level(fired[i], ch_active_high_in[i]);
      assign ch_used[i] = (ch_mode_in[i] != MODE_OFF);
    end
  endgenerate

  assign general_out_one = ch_level[CH_GENERAL_OUT_ONE];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign level_rst = !r.ext_rst_n_sync[1] || !r.pwr_ok_sync[1];
  assign event_rst = alarm_reseq_in
                     || (restart_wr_in && restart_data_in == RESTART_VALUE);

  always_comb begin
    n = r;
    n.ext_rst_n_sync = {r.ext_rst_n_sync[0], ext_reset_n_in};
    n.pwr_ok_sync = {r.pwr_ok_sync[0], power_ok_in};
    n.addr_s1 = bus_addr_select_in;
    n.addr_s2 = r.addr_s1;
    for (int k = 0; k < NUM_RAILS; k++) begin
      n.in_reg[k] = in_window(rail_sense_in[k], uv_limit_in[k],
                              ov_limit_in[k]);
    end
    // Millisecond tick only runs once the sequence is live
    n.ms_tick = 1'b0;
    n.tick_cnt = '0;
    if (run) begin
      if (r.tick_cnt == TICK_LAST) begin
        n.ms_tick = 1'b1;
      end else begin
        n.tick_cnt = r.tick_cnt + 1'b1;
      end
    end
    case (r.state)
      ST_HOLD: begin
        if (level_rst || event_rst) begin
          n.hold_cnt = HOLD_LOAD;
        end else if (r.hold_cnt == '0) begin
          n.state = ST_LATCH;
        end else begin
          n.hold_cnt = r.hold_cnt - 1'b1;
        end
      end
      ST_LATCH: begin
        // A request landing in the latch cycle must not be lost
        if (level_rst || event_rst) begin
          n.state = ST_HOLD;
          n.hold_cnt = HOLD_LOAD;
        end else begin
          n.addr = r.addr_s2;
          n.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (level_rst || event_rst) begin
          n.state = ST_HOLD;
          n.hold_cnt = HOLD_LOAD;
        end
      end
      default: begin
        n.state = ST_HOLD;
        n.hold_cnt = HOLD_LOAD;
      end
    endcase
    // Pins float from one cycle after the live sequence ends, including the latch cycle
    n.rail_drv = ch_level[NUM_RAILS-2:0];
    n.rail_oe = run ? ch_used[NUM_RAILS-2:0] : '0;
    n.gpo_drv = ch_level[NUM_CH-1:CH_GENERAL_OUT_ONE+1];
    n.gpo_oe = run ? ch_used[NUM_CH-1:CH_GENERAL_OUT_ONE+1] : '0;
    if (rail8_as_gpo_in) begin
      n.pin8_drv = general_out_one;
      n.pin8_oe = run && ch_used[CH_GENERAL_OUT_ONE];
    end else begin
      n.pin8_drv = ch_level[CH_RAIL8];
      n.pin8_oe = run && ch_used[CH_RAIL8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.state <= ST_HOLD;
      r.hold_cnt <= HOLD_LOAD;
    end else if (clk_en_in) begin
      r <= n;
    end
  end

  assign rail_enable_out = r.rail_drv;
  assign rail_enable_oe_out = r.rail_oe;
  assign rail8_enable_out = r.pin8_drv;
  assign rail8_enable_oe_out = r.pin8_oe;
  assign general_out = r.gpo_drv;
  assign general_oe_out = r.gpo_oe;
  assign seq_reset_out = !run;
  assign bus_addr_out = BUS_ADDR_BASE
                        | {4'h0, r.addr};
  assign rail_in_reg_out = r.in_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in iff clk_en_in);
  endclocking
  default disable iff (rst_in);

  AST_FLOAT_IN_RESET: assert property (
    (r.state != ST_RUN) |=> (r.rail_oe == '0 && !r.pin8_oe
                             && r.gpo_oe == '0))
    else $error("output driven during sequencer reset");
  AST_EXT_RESET: assert property (
    !r.ext_rst_n_sync[1] |=> (r.state == ST_HOLD && r.hold_cnt == HOLD_LOAD))
    else $error("external reset did not hold the sequencer");
  AST_POWER_RESET: assert property (
    !r.pwr_ok_sync[1] |=> r.state == ST_HOLD)
    else $error("power loss did not hold the sequencer");
  AST_ALARM_RESET: assert property (
    alarm_reseq_in |=> (r.state == ST_HOLD && r.hold_cnt == HOLD_LOAD))
    else $error("alarm did not restart the sequencer");
  AST_RESTART_ZERO: assert property (
    (restart_wr_in && restart_data_in == RESTART_VALUE)
    |=> r.state == ST_HOLD ##1 r.rail_oe == '0)
    else $error("restart write of zero ignored");
  AST_HOLD_LENGTH: assert property (
    (r.state == ST_LATCH) |-> ($past(r.state) == ST_HOLD
                               && $past(r.hold_cnt) == '0))
    else $error("hold interval cut short");
  AST_ADDR_LATCH: assert property (
    (r.state == ST_LATCH && !level_rst && !event_rst)
    |=> (r.addr == $past(r.addr_s2)
      && bus_addr_out[BUS_ADDR_LSB +: ADDR_SEL_W] == $past(r.addr_s2)))
    else $error("address not latched on release");
  AST_GPO_AFTER_ADDR: assert property (
    (r.gpo_oe != '0) |-> ($past(r.state) == ST_RUN
                          && $past(r.state, 2) != ST_HOLD))
    else $error("general pin driven before address latch");
  AST_PIN8_SHARE: assert property (
    (run && rail8_as_gpo_in && !ch_used[CH_GENERAL_OUT_ONE]) |=> !r.pin8_oe)
    else $error("eighth pin driven by unused general output");
  AST_EXCLUDED_RAIL: assert property (
    (ch_used[NUM_RAILS-2:0] != '1)
    |=> ((r.rail_oe & ~$past(ch_used[NUM_RAILS-2:0])) == '0))
    else $error("excluded rail enable driven");
  AST_POLARITY: assert property (
    (run && !fired[0]) |=> (r.rail_drv[0] == !$past(ch_active_high_in[0])))
    else $error("idle enable not at deasserted level");
  AST_LATCH_ABORT: assert property (
    (r.state == ST_LATCH && (level_rst || event_rst)) |=> r.state == ST_HOLD)
    else $error("reset request lost in latch cycle");
  AST_TICK_CLEAR: assert property (
    !run |=> (r.tick_cnt == '0 && !r.ms_tick))
    else $error("millisecond timer ran during sequencer reset");
  AST_ADDR_HELD: assert property (
    (r.state == ST_RUN && $past(r.state) == ST_RUN) |-> $stable(r.addr))
    else $error("bus address changed while running");

  COV_RELEASE: cover property (r.state == ST_HOLD ##1 r.state == ST_LATCH);
  COV_ALARM_RESEQ: cover property (r.state == ST_RUN && alarm_reseq_in);
  COV_PIN8_GPO: cover property (r.pin8_oe && rail8_as_gpo_in);
  COV_PIN8_RAIL: cover property (r.pin8_oe && !rail8_as_gpo_in);
  COV_ALL_FIRED: cover property (run && fired == '1);

endmodule // rail_enable_sequencer

//--- supply_model.sv
// Far side of the sequencer: pull networks on every enable and general
// pin, and supplies whose measured voltage follows their enable.
// Assumes pin vectors ordered rails 1..7, eighth pin, general outs 2..4.
`timescale 1ns/1ps
module supply_model
  import rail_seq_pkg::*;
#(
  parameter logic [rail_seq_pkg::VOLT_W-1:0] NOM_V = 10'h226
)
(
  // Pin side
  input wire logic [10:0] pin_val_in,
  input wire logic [10:0] pin_oe_in,
  input wire logic [10:0] pull_in,
  // Supply setup
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0] rail_act_in,
  input wire logic rail8_as_gpo_in,
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0][rail_seq_pkg::VOLT_W-1:0]
    idle_v_in,
  // Resolved levels
  output logic [10:0] pin_lvl_out,
  output logic [rail_seq_pkg::NUM_RAILS-1:0][rail_seq_pkg::VOLT_W-1:0]
    rail_v_out
);
  import rail_seq_pkg::*;
  logic [NUM_RAILS-1:0] on;
  // Released pins fall to the pull level, never to the last driven value
  assign pin_lvl_out = (pin_oe_in & pin_val_in) | (~pin_oe_in & pull_in);
  always_comb begin
    for (int i = 0; i < NUM_RAILS; i++) begin
      on[i] = pin_oe_in[i] && (pin_lvl_out[i] == rail_act_in[i]);
      // A pin lent to the general output powers no supply
      if (i == NUM_RAILS - 1 && rail8_as_gpo_in) begin
        on[i] = 1'b0;
      end
      rail_v_out[i] = on[i] ? NOM_V : idle_v_in[i];
    end
  end
endmodule // supply_model

//--- tb.sv
// Self-checking bench for the rail enable sequencer.
// Assumes the far side is supply_model and a 25 MHz clock.
`timescale 1ns/1ps
module tb;
  import rail_seq_pkg::*;
  localparam int HOLD = 20;
  localparam int MS = 5;
  logic clk_sys_in, rst_in, ext_reset_n, power_ok, alarm, restart_wr;
  logic [7:0] restart_data, addr, in_reg;
  logic [NUM_RAILS-1:0][VOLT_W-1:0] sense, uv, ov, idle_v;
  logic [NUM_CH-1:0][1:0] mode;
  logic [NUM_CH-1:0][PAR_W-1:0] parent;
  logic [NUM_CH-1:0][DLY_W-1:0] dly;
  logic [NUM_CH-1:0][VOLT_W-1:0] thr;
  logic [NUM_CH-1:0] act;
  logic gpo_sel, seq_reset, r8, r8_oe;
  logic [6:0] en, en_oe;
  logic [2:0] gp, gp_oe;
  logic [10:0] pin_lvl, pull, pin_oe;
  int miscompares, total_checks;
  int t_oe[11];
  int t_on[11];
  int used[7] = '{0, 1, 2, 7, 8, 9, 10};

  function automatic int ch_of(int p);
    if (p < 7) return p;
    if (p == 7) return gpo_sel ? 8 : 7;
    return p + 1;
  endfunction

  // Pulls hold each pin at its deasserted level while released
  always_comb begin
    for (int p = 0; p < 11; p++) pull[p] = ~act[ch_of(p)];
  end
  assign pin_oe = {gp_oe, r8_oe, en_oe};

  rail_enable_sequencer #(.RESEQ_HOLD_CYCLES(HOLD), .MS_CYCLES(MS)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .ext_reset_n_in(ext_reset_n), .power_ok_in(power_ok),
    .alarm_reseq_in(alarm), .restart_wr_in(restart_wr),
    .restart_data_in(restart_data), .rail_sense_in(sense),
    .uv_limit_in(uv), .ov_limit_in(ov), .ch_mode_in(mode),
    .ch_parent_in(parent), .ch_delay_ms_in(dly), .ch_threshold_in(thr),
    .ch_active_high_in(act), .rail8_as_gpo_in(gpo_sel),
    .bus_addr_select_in(pin_lvl[10:7]), .rail_enable_out(en),
    .rail_enable_oe_out(en_oe), .rail8_enable_out(r8),
    .rail8_enable_oe_out(r8_oe), .general_out(gp), .general_oe_out(gp_oe),
    .seq_reset_out(seq_reset), .bus_addr_out(addr),
    .rail_in_reg_out(in_reg));

  supply_model i_far (
    .pin_val_in({gp, r8, en}), .pin_oe_in(pin_oe),
    .pull_in(pull), .rail_act_in(act[7:0]), .rail8_as_gpo_in(gpo_sel),
    .idle_v_in(idle_v), .pin_lvl_out(pin_lvl), .rail_v_out(sense));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(string what, int lo, int hi, int got);
    total_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Runs one power-up sequence from the end of reset and times every pin
  task automatic run_check();
    int n;
    logic [3:0] idle_oe;
    n = 0;
    idle_oe = 4'h0;
    while (seq_reset !== 1'b0) begin
      @(negedge clk_sys_in);
      n++;
      if (n > 300) begin
        miscompares++;
        finish_test();
      end
    end
    chk("bus address", BUS_ADDR_BASE | {4'h0, pull[10:7]}, addr);
    for (int p = 0; p < 11; p++) begin
      t_oe[p] = -1;
      t_on[p] = -1;
    end
    for (int k = 1; k <= 60; k++) begin
      @(negedge clk_sys_in);
      idle_oe |= en_oe[6:3];
      for (int p = 0; p < 11; p++) begin
        if (pin_oe[p] === 1'b1) begin
          if (t_oe[p] < 0) t_oe[p] = k;
          if (t_on[p] < 0 && pin_lvl[p] === act[ch_of(p)]) t_on[p] = k;
        end
      end
    end
    chk_rng("rail1 time delay", 2 * MS, 2 * MS + 4, t_on[0]);
    chk_rng("rail2 parent lag", 1, MS + 5, t_on[1] - t_on[0]);
    chk_rng("rail3 threshold lag", 1, 4, t_on[2] - t_on[0]);
    chk_rng("pin8 delay", dly[ch_of(7)] * MS, dly[ch_of(7)] * MS + 4,
      t_on[7]);
    for (int p = 8; p < 11; p++) begin
      chk_rng("general delay", dly[p + 1] * MS, dly[p + 1] * MS + 4,
        t_on[p]);
    end
    foreach (used[i]) begin
      chk_rng("deasserted first", 1, t_on[used[i]] - 1, t_oe[used[i]]);
      chk("pin level", {15'h0, act[ch_of(used[i])]},
        {15'h0, pin_lvl[used[i]]});
    end
    chk("excluded oe", 16'h0, {12'h0, idle_oe});
    chk("regulation", {8'h0, ~gpo_sel, 7'b0101111}, {8'h0, in_reg});
  endtask

  // Kinds: 0 alarm, 1 restart write, 2 reset pin, 3 power cycle
  task automatic reseq(int kind);
    int n;
    @(negedge clk_sys_in);
    case (kind)
      0: alarm = 1'b1;
      1: restart_wr = 1'b1;
      2: ext_reset_n = 1'b0;
      default: power_ok = 1'b0;
    endcase
    restart_data = 8'h00;
    @(negedge clk_sys_in);
    alarm = 1'b0;
    restart_wr = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk("reset flag", 16'h1, {15'h0, seq_reset});
    chk("oe in reset", 16'h0, {5'h0, gp_oe, r8_oe, en_oe});
    gpo_sel = (kind == 3);
    ext_reset_n = 1'b1;
    power_ok = 1'b1;
    n = 5;
    while (seq_reset === 1'b1 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      finish_test();
    end
    chk_rng("reset length", HOLD + (kind > 1 ? 5 : 0),
      HOLD + (kind > 1 ? 12 : 6), n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    rst_in = 1'b1;
    ext_reset_n = 1'b1;
    power_ok = 1'b1;
    alarm = 1'b0;
    restart_wr = 1'b0;
    restart_data = 8'h00;
    gpo_sel = 1'b0;
    miscompares = 0;
    total_checks = 0;
    for (int i = 0; i < NUM_CH; i++) begin
      mode[i] = MODE_OFF;
      parent[i] = 3'h0;
      dly[i] = 16'h1;
      thr[i] = 10'h0;
      act[i] = 1'b1;
    end
    for (int i = 0; i < NUM_RAILS; i++) begin
      uv[i] = 10'h190;
      ov[i] = 10'h258;
      idle_v[i] = 10'h0;
    end
    // Monitored but unsequenced rails sit on and just past both limits
    idle_v[3] = 10'h190;
    idle_v[4] = 10'h259;
    idle_v[5] = 10'h258;
    idle_v[6] = 10'h18f;
    mode[0] = MODE_TIME;
    dly[0] = 16'h2;
    mode[1] = MODE_PARENT_REG;
    act[1] = 1'b0;
    mode[2] = MODE_PARENT_THR;
    thr[2] = 10'h1f4;
    mode[7] = MODE_TIME;
    dly[7] = 16'h4;
    mode[8] = MODE_TIME;
    act[8] = 1'b0;
    for (int c = 9; c < 12; c++) begin
      mode[c] = MODE_TIME;
      dly[c] = 16'(c - 8);
      act[c] = c[0];
    end
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    run_check();
    @(negedge clk_sys_in);
    restart_wr = 1'b1;
    restart_data = 8'h5a;
    @(negedge clk_sys_in);
    restart_wr = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk("nonzero restart", 16'h0, {15'h0, seq_reset});
    for (int k = 0; k < 4; k++) begin
      reseq(k);
      run_check();
    end
    finish_test();
  end
endmodule // tb
